// ==== tws_slave.sv ====
// two-wire bus slave with apb register access
`default_nettype none

// Contract
// R1: own address sits in bits 7..1 of the address register, bit 7 is msb.
// R2: address register bit 0 is plain storage, ignored by matching.
// R3: start is sda falling while scl high, watched at all times. The code watches it only while enabled in slave mode.
// R4: start sets the bus-busy flag.
// R5: first seven bits after start are the calling address, msb first, compared.
// R6: address equal sets address-match flag and raises the interrupt request.
// R7: eighth bit after start is captured as read/write, one means master reads.
// R8: on address match sda is pulled low during the ninth clock.
// R9: one interrupt request serves address match and byte completion.
// R10: after match scl held low until data write (tx) or read (rx).
// R11: direction-select bit one makes transmitter, zero makes receiver.
// R12: data bytes are eight bits, msb first, only after address acknowledge.
// R13: receiving, transmit-acknowledge bit is driven on the ninth clock.
// R14: transmitting, ninth-clock sda is sampled into receive-acknowledge flag.
// R15: transmitting, no acknowledge releases sda and waits for stop.
// R16: received bytes land in data register, transmitted bytes come from it.
// R17: only the master makes start; this slave never drives one.
// R18: master ends with stop when its calling address gets no acknowledge.
// R19: enable mode and module, write address, then enable interrupt.
// R20: stop clears the bus-busy flag.
// R21: transfer-complete low while byte moves, set with interrupt at byte end.
// R22: mode field code 110 selects the two-wire slave function.
// R23: scl and sda are synchronised and edge-detected before any decoding.
module tws_slave
	import tws_pkg::*;
(
	input wire logic i_clk, // system clock, 25 mhz
	input wire logic i_resetn, // sync reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb access phase
	input wire logic i_pwrite, // apb write
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	input wire logic i_scl, // scl pin level
	output logic o_scl_out, // scl drive value, always low
	output logic o_scl_oe, // scl pulled low when high
	input wire logic i_sda, // sda pin level
	output logic o_sda_out, // sda drive value, always low
	output logic o_sda_oe, // sda pulled low when high
	output logic o_irq // interrupt request pulse
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	tws_state_t state_q;
	tws_pins_t pins_in;
	tws_pins_t lvl;
	tws_pins_t rise;
	tws_pins_t fall;
	logic [2:0] mode_q;
	logic enable_q;
	logic htx_q;
	logic transmit_ack_bit_q;
	logic wake_q;
	logic irqen_q;
	logic [7:0] own_addr_q;
	logic [7:0] data_q;
	logic [7:0] shreg_q;
	logic [3:0] cnt_q;
	logic hcf_q;
	logic address_match_flag_q;
	logic hbb_q;
	logic srw_q;
	logic receive_ack_flag_q;
	logic sda_oe_d;
	logic sda_oe_q;
	logic scl_oe_q;
	logic lead_q;
	logic [31:0] prdata_q;
	logic active;
	logic start_det;
	logic stop_det;
	logic addr_bit;
	logic addr_match;
	logic byte_end;
	logic ack_end;
	logic sw_wr;
	logic sw_rd;
	logic data_wr;
	logic data_rd;
	logic release_hold;
	logic mapped;

	// ----------------------------------------------------------------
	// line conditioning
	// ----------------------------------------------------------------
	assign pins_in = '{scl: i_scl, sda: i_sda};

	// see R23
	tws_sync i_tws_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_pins(pins_in),
		.o_level(lvl),
		.o_rise(rise),
		.o_fall(fall)
	);

	assign active = enable_q && (mode_q == TWS_MODE_SLAVE); // see R22
	// an sda change seen in the same sample as the scl rise is data, not start or stop
	assign start_det = active && fall.sda && lvl.scl && !rise.scl; // see R3
	assign stop_det = active && rise.sda && lvl.scl && !rise.scl; // see R20
	assign addr_bit = (state_q == TWS_S_ADDR) && rise.scl && (cnt_q == TWS_CNT_ADDR_LAST);
	// shreg holds the seven address bits, the live sda is the direction bit
	assign addr_match = shreg_q[6:0] == own_addr_q[7:1]; // see R1, R2, R5
	assign byte_end = (state_q == TWS_S_DATA) && fall.scl && (cnt_q == TWS_CNT_BYTE);
	assign ack_end = fall.scl && (cnt_q == TWS_CNT_ACK);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign mapped = (i_paddr == TWS_OFF_MODCTL) || (i_paddr == TWS_OFF_CTLSTS) ||
		(i_paddr == TWS_OFF_DATA) || (i_paddr == TWS_OFF_ADDR) || (i_paddr == TWS_OFF_IRQEN);
	assign sw_wr = i_psel && i_penable && i_pwrite && mapped;
	assign sw_rd = i_psel && i_penable && !i_pwrite && mapped;
	assign data_wr = sw_wr && (i_paddr == TWS_OFF_DATA);
	assign data_rd = sw_rd && (i_paddr == TWS_OFF_DATA);
	// a dummy data read or a data write lets the master go on
	assign release_hold = (state_q == TWS_S_WAIT) && (htx_q ? data_wr : data_rd); // see R10, R11
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign o_prdata = prdata_q;

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			prdata_q <= 32'h0000_0000;
		else if (i_psel && !i_penable && !i_pwrite)
		begin
			prdata_q <= 32'h0000_0000;
			case (i_paddr)
				TWS_OFF_MODCTL:
				begin
					prdata_q[TWS_MODE_HI:TWS_MODE_LO] <= mode_q;
					prdata_q[TWS_ENABLE_BIT] <= enable_q;
				end
				TWS_OFF_CTLSTS:
				begin
					prdata_q[TWS_HCF_BIT] <= hcf_q;
					prdata_q[TWS_ADDRESS_MATCH_FLAG_BIT] <= address_match_flag_q; // see R9
					prdata_q[TWS_HBB_BIT] <= hbb_q;
					prdata_q[TWS_HTX_BIT] <= htx_q;
					prdata_q[TWS_TRANSMIT_ACK_BIT_BIT] <= transmit_ack_bit_q;
					prdata_q[TWS_SRW_BIT] <= srw_q;
					prdata_q[TWS_WAKE_BIT] <= wake_q;
					prdata_q[TWS_RECEIVE_ACK_FLAG_BIT] <= receive_ack_flag_q;
				end
				TWS_OFF_DATA: prdata_q[7:0] <= data_q;
				TWS_OFF_ADDR: prdata_q[7:0] <= own_addr_q;
				TWS_OFF_IRQEN: prdata_q[TWS_IRQEN_BIT] <= irqen_q;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// software-written control
	// ----------------------------------------------------------------
	// see R19
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			mode_q <= TWS_MODE_RST;
			enable_q <= 1'b0;
			htx_q <= 1'b0;
			transmit_ack_bit_q <= 1'b0;
			wake_q <= 1'b0;
			irqen_q <= 1'b0;
			own_addr_q <= TWS_BYTE_RST;
		end
		else if (sw_wr)
		begin
			case (i_paddr)
				TWS_OFF_MODCTL:
				begin
					mode_q <= i_pwdata[TWS_MODE_HI:TWS_MODE_LO];
					enable_q <= i_pwdata[TWS_ENABLE_BIT];
				end
				TWS_OFF_CTLSTS:
				begin
					htx_q <= i_pwdata[TWS_HTX_BIT];
					transmit_ack_bit_q <= i_pwdata[TWS_TRANSMIT_ACK_BIT_BIT];
					wake_q <= i_pwdata[TWS_WAKE_BIT];
				end
				TWS_OFF_ADDR: own_addr_q <= i_pwdata[7:0]; // see R2
				TWS_OFF_IRQEN: irqen_q <= i_pwdata[TWS_IRQEN_BIT];
				default: own_addr_q <= own_addr_q;
			endcase
		end
	end

	// shared data register: software load or received byte
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			data_q <= TWS_BYTE_RST;
		else if (byte_end && !htx_q)
			data_q <= shreg_q; // see R16
		else if (data_wr)
			data_q <= i_pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// bus sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !active)
		begin
			state_q <= TWS_S_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= TWS_BYTE_RST;
		end
		else if (start_det)
		begin
			// a repeated start restarts address reception from any state
			state_q <= TWS_S_ADDR; // see R3
			cnt_q <= 4'h0;
		end
		else if (stop_det)
			state_q <= TWS_S_IDLE;
		else
		begin
			case (state_q)
				TWS_S_IDLE: state_q <= TWS_S_IDLE;
				TWS_S_ADDR:
				begin
					if (rise.scl)
					begin
						shreg_q <= {shreg_q[6:0], lvl.sda}; // see R5
						cnt_q <= cnt_q + 4'h1;
					end
					else if (fall.scl && cnt_q == TWS_CNT_BYTE)
						state_q <= address_match_flag_q ? TWS_S_AACK : TWS_S_IDLE;
				end
				TWS_S_AACK, TWS_S_DACK:
				begin
					if (rise.scl)
						cnt_q <= cnt_q + 4'h1;
					else if (ack_end)
					begin
						cnt_q <= 4'h0;
						// a refused byte frees the lines until stop
						if (state_q == TWS_S_DACK && htx_q && receive_ack_flag_q)
							state_q <= TWS_S_IDLE; // see R15
						else
							state_q <= TWS_S_WAIT; // see R10
					end
				end
				TWS_S_WAIT:
				begin
					if (release_hold)
					begin
						state_q <= TWS_S_DATA; // see R12
						if (htx_q)
							shreg_q <= i_pwdata[7:0]; // see R16
					end
				end
				TWS_S_DATA:
				begin
					if (rise.scl)
					begin
						cnt_q <= cnt_q + 4'h1;
						if (!htx_q)
							shreg_q <= {shreg_q[6:0], lvl.sda}; // see R12
					end
					else if (byte_end)
						state_q <= TWS_S_DACK;
					else if (fall.scl && htx_q)
						shreg_q <= {shreg_q[6:0], 1'b0}; // see R12
				end
				default: state_q <= TWS_S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !active)
		begin
			hbb_q <= 1'b0;
			address_match_flag_q <= 1'b0;
			srw_q <= 1'b0;
			hcf_q <= TWS_HCF_RST;
			receive_ack_flag_q <= TWS_RECEIVE_ACK_FLAG_RST;
		end
		else
		begin
			if (start_det)
				hbb_q <= 1'b1; // see R4
			else if (stop_det)
				hbb_q <= 1'b0; // see R20
			if (start_det)
				address_match_flag_q <= 1'b0;
			else if (addr_bit)
			begin
				address_match_flag_q <= addr_match; // see R6
				srw_q <= lvl.sda; // see R7
			end
			else if (byte_end)
				address_match_flag_q <= 1'b0; // see R9
			if (release_hold || start_det)
				hcf_q <= 1'b0; // see R21
			else if (byte_end)
				hcf_q <= 1'b1; // see R21
			if (state_q == TWS_S_DACK && htx_q && rise.scl)
				receive_ack_flag_q <= lvl.sda; // see R14
		end
	end

	// one request line for both events
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			o_irq <= 1'b0;
		else
			o_irq <= irqen_q && active && ((addr_bit && addr_match) || byte_end); // see R6, R9, R21
	end

	// ----------------------------------------------------------------
	// open-drain drivers
	// ----------------------------------------------------------------
	always_comb
	begin
		sda_oe_d = 1'b0;
		case (state_q)
			TWS_S_AACK: sda_oe_d = 1'b1; // see R8
			TWS_S_DATA: sda_oe_d = htx_q && !shreg_q[7]; // see R11, R12
			TWS_S_DACK: sda_oe_d = !htx_q && !transmit_ack_bit_q; // see R13
			default: sda_oe_d = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !active)
		begin
			sda_oe_q <= 1'b0;
			scl_oe_q <= 1'b0;
			lead_q <= 1'b0;
		end
		else
		begin
			sda_oe_q <= sda_oe_d;
			// scl stays low one cycle longer so a first tx bit is on sda before scl rises
			lead_q <= release_hold;
			scl_oe_q <= (state_q == TWS_S_WAIT) || lead_q; // see R10
		end
	end

	// the slave only ever pulls low, so no start can come from here
	assign o_sda_out = 1'b0; // see R17
	assign o_scl_out = 1'b0;
	assign o_sda_oe = sda_oe_q;
	assign o_scl_oe = scl_oe_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence seq_addr_hit;
		addr_bit && addr_match && active && !start_det && !stop_det;
	endsequence

	sequence seq_stall_then_go;
		(state_q == TWS_S_WAIT) ##0 release_hold;
	endsequence

	AST_START_BUSY: assert property (start_det |=> hbb_q) // see R4
		else $error("start did not set busy");
	AST_STOP_FREE: assert property (stop_det && !start_det |=> !hbb_q) // see R20
		else $error("stop did not clear busy");
	AST_MATCH_IRQ: assert property (seq_addr_hit |=> address_match_flag_q && (o_irq == irqen_q)) // see R6
		else $error("address match not flagged");
	AST_DIR_BIT: assert property (seq_addr_hit |=> srw_q == $past(lvl.sda)) // see R7
		else $error("direction bit not captured");
	AST_ADDR_ACK: assert property ((state_q == TWS_S_AACK) ##1 (state_q == TWS_S_AACK) |-> o_sda_oe) // see R8
		else $error("address not acknowledged");
	AST_STRETCH: assert property ($rose(state_q == TWS_S_WAIT) |=> o_scl_oe) // see R10
		else $error("scl not held after event");
	AST_RELEASE: assert property (seq_stall_then_go |=> (state_q == TWS_S_DATA) && o_scl_oe ##2 !o_scl_oe) // see R10
		else $error("scl not released on service");
	AST_RX_ACK: assert property ((state_q == TWS_S_DACK) && !htx_q ##1 (state_q == TWS_S_DACK)
		|-> o_sda_oe == !$past(transmit_ack_bit_q)) // see R13
		else $error("receive acknowledge wrong");
	AST_HCF_BUSY: assert property ((state_q == TWS_S_DATA) |-> !hcf_q) // see R21
		else $error("complete flag high mid byte");
	AST_BYTE_DONE: assert property (byte_end && !start_det && !stop_det |=> hcf_q ##1 (state_q == TWS_S_DACK)) // see R21
		else $error("byte end not flagged");
	AST_NACK_FREE: assert property ((state_q == TWS_S_DACK) && htx_q && receive_ack_flag_q && ack_end && !start_det && !stop_det
		|=> (state_q == TWS_S_IDLE) ##1 !o_sda_oe && !o_scl_oe) // see R15
		else $error("lines not freed on refusal");
	AST_MODE_OFF: assert property (!active |=> !o_sda_oe && !o_scl_oe) // see R22
		else $error("lines driven while disabled");

endmodule // tws_slave

`default_nettype wire

// ==== tws_pkg.sv ====
// constants, types and register map of the two-wire slave
`default_nettype none

package tws_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TWS_OFF_MODCTL = 8'h00;
	localparam logic [7:0] TWS_OFF_CTLSTS = 8'h04;
	localparam logic [7:0] TWS_OFF_DATA = 8'h08;
	localparam logic [7:0] TWS_OFF_ADDR = 8'h0c;
	localparam logic [7:0] TWS_OFF_IRQEN = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TWS_MODE_HI = 7;
	localparam int TWS_MODE_LO = 5;
	localparam int TWS_ENABLE_BIT = 1;
	localparam int TWS_HCF_BIT = 7;
	localparam int TWS_ADDRESS_MATCH_FLAG_BIT = 6;
	localparam int TWS_HBB_BIT = 5;
	localparam int TWS_HTX_BIT = 4;
	localparam int TWS_TRANSMIT_ACK_BIT_BIT = 3;
	localparam int TWS_SRW_BIT = 2;
	localparam int TWS_WAKE_BIT = 1;
	localparam int TWS_RECEIVE_ACK_FLAG_BIT = 0;
	localparam int TWS_IRQEN_BIT = 0;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] TWS_MODE_SLAVE = 3'h6;
	localparam logic [2:0] TWS_MODE_RST = 3'h7;
	localparam logic TWS_HCF_RST = 1'b1;
	localparam logic TWS_RECEIVE_ACK_FLAG_RST = 1'b1;
	localparam logic [7:0] TWS_BYTE_RST = 8'h00;
	localparam logic [3:0] TWS_CNT_ADDR_LAST = 4'h7;
	localparam logic [3:0] TWS_CNT_BYTE = 4'h8;
	localparam logic [3:0] TWS_CNT_ACK = 4'h9;

	typedef enum logic [2:0] {
		TWS_S_IDLE = 3'b000,
		TWS_S_ADDR = 3'b001,
		TWS_S_AACK = 3'b010,
		TWS_S_WAIT = 3'b011,
		TWS_S_DATA = 3'b100,
		TWS_S_DACK = 3'b101
	} tws_state_t;

	// open-drain pin pair, bit order used by the synchroniser
	typedef struct packed {
		logic scl;
		logic sda;
	} tws_pins_t;

endpackage

`default_nettype wire

// ==== tws_sync.sv ====
// two-flop synchroniser with edge detection for the bus lines
`default_nettype none

module tws_sync
	import tws_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_resetn, // sync reset, active low
	input wire tws_pins_t i_pins, // raw pin levels
	output tws_pins_t o_level, // synchronised levels
	output tws_pins_t o_rise, // one-cycle rising edge
	output tws_pins_t o_fall // one-cycle falling edge
);

	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_line
			// idle bus lines are pulled high, so reset to one
			always_ff @(posedge i_clk)
			begin
				if (!i_resetn)
				begin
					meta_q[g] <= 1'b1;
					sync_q[g] <= 1'b1;
					prev_q[g] <= 1'b1;
				end
				else
				begin
					meta_q[g] <= i_pins[g];
					sync_q[g] <= meta_q[g];
					prev_q[g] <= sync_q[g];
				end
			end
		end
	endgenerate

	assign o_level = sync_q;
	assign o_rise = sync_q & ~prev_q;
	assign o_fall = ~sync_q & prev_q;

endmodule // tws_sync

`default_nettype wire

// ==== tws_bus_master_model.sv ====
// behavioural two-wire bus master driving the far side of the slave
`default_nettype none

module tws_bus_master_model
	import tws_pkg::*;
#(
	parameter int HALF = 160
)
(
	input wire logic i_scl, // resolved scl line
	input wire logic i_sda, // resolved sda line
	output logic o_scl_oe, // pull scl low
	output logic o_sda_oe, // pull sda low
	output logic o_timeout // stretch wait ran out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
		o_timeout = 1'b0;
	end

	// ----------------------------------------------------------------
	// bit level
	// ----------------------------------------------------------------
	// keep start, stop and the bits run straight after them off the slave's clock edges, avoiding sampling races
	task automatic align();
		while ($time % 10 != 5)
			#1;
	endtask

	// a held-low line means the slave stretches: read the line back
	task automatic wait_high();
		int n;
		n = 0;
		while (i_scl !== 1'b1 && n < 2000)
		begin
			#10;
			n++;
		end
		if (n >= 2000)
			o_timeout = 1'b1;
	endtask

	// sda only moves well after scl has gone low
	task automatic bit_x(input logic b, output logic s);
		#40 o_sda_oe = !b;
		#(HALF - 40) o_scl_oe = 1'b0;
		wait_high();
		#(HALF / 2) s = i_sda;
		#(HALF / 2) o_scl_oe = 1'b1;
	endtask

	task automatic start();
		align();
		o_sda_oe = 1'b1;
		#HALF o_scl_oe = 1'b1;
	endtask

	task automatic stop();
		align();
		#40 o_sda_oe = 1'b1;
		#(HALF - 40) o_scl_oe = 1'b0;
		wait_high();
		#HALF o_sda_oe = 1'b0;
		#HALF;
	endtask

	// ----------------------------------------------------------------
	// byte level
	// ----------------------------------------------------------------
	// extra low time after the ack clock lets the slave grab scl
	task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(ack_in, ack);
		#HALF;
	endtask
endmodule // tws_bus_master_model

`default_nettype wire

// ==== tb_tws_slave.sv ====
// self-checking testbench of the two-wire slave
`default_nettype none

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_tws_slave
	import tws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, s_scl_out, s_scl_oe, s_sda_out, s_sda_oe, irq;
	logic m_scl_oe, m_sda_oe, m_to;
	wire logic scl_w;
	wire logic sda_w;
	int num_errors = 0;
	int tests_run = 0;
	int irq_cnt = 0;
	logic [31:0] rd;
	logic err, ack, ack2, ack3;
	logic [7:0] q, q2, q3;

	// open-drain lines with pull-ups
	assign scl_w = !(s_scl_oe | m_scl_oe);
	assign sda_w = !(s_sda_oe | m_sda_oe);

	initial
	begin
		forever #20 clk = !clk;
	end

	tws_slave i_tws_slave (.i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_scl(scl_w), .o_scl_out(s_scl_out), .o_scl_oe(s_scl_oe), .i_sda(sda_w),
		.o_sda_out(s_sda_out), .o_sda_oe(s_sda_oe), .o_irq(irq));

	tws_bus_master_model #(.HALF(160)) i_tws_bus_master_model (.i_scl(scl_w), .i_sda(sda_w),
		.o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe), .o_timeout(m_to));

	always @(posedge clk)
	begin
		if (irq === 1'b1)
			irq_cnt <= irq_cnt + 1;
	end

	always @(posedge m_to)
	begin
		num_errors++;
		summarize();
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			if (++n > 50)
			begin
				num_errors++;
				summarize();
			end
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_irq(input int k);
		int n;
		n = 0;
		while (irq_cnt < k)
		begin
			@(posedge clk);
			if (++n > 5000)
			begin
				num_errors++;
				summarize();
			end
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b0, TWS_OFF_MODCTL, 32'h0);
		`CHK("mode reset", 32'h000000e0, rd)
		apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
		`CHK("status reset", 32'h00000081, rd)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		`CHK("pins drive low", 2'b00, {s_scl_out, s_sda_out})
		apb(1'b1, TWS_OFF_MODCTL, 32'h000000c2);
		apb(1'b1, TWS_OFF_ADDR, 32'h00000055);
		apb(1'b1, TWS_OFF_IRQEN, 32'h00000001);
		apb(1'b0, TWS_OFF_ADDR, 32'h0);
		`CHK("own address", 32'h00000055, rd)
		// another slave is called: busy but no ack
		i_tws_bus_master_model.start();
		apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
		`CHK("busy on start", 1'b1, rd[TWS_HBB_BIT])
		i_tws_bus_master_model.xbyte(8'h56, 1'b1, q, ack);
		`CHK("no ack other", 1'b1, ack)
		i_tws_bus_master_model.stop();
		`CHK("no irq other", 0, irq_cnt)
		apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
		`CHK("free on stop", 1'b0, rd[TWS_HBB_BIT])
		// master writes one byte
		i_tws_bus_master_model.start();
		fork
			begin
				i_tws_bus_master_model.xbyte(8'h54, 1'b1, q, ack);
				i_tws_bus_master_model.xbyte(8'h3c, 1'b1, q, ack2);
			end
			begin
				wait_irq(1);
				repeat (22) @(posedge clk);
				`CHK("scl stretched", 1'b0, scl_w)
				apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
				`CHK("addr match", 1'b1, rd[TWS_ADDRESS_MATCH_FLAG_BIT])
				`CHK("dir write", 1'b0, rd[TWS_SRW_BIT])
				apb(1'b0, TWS_OFF_DATA, 32'h0);
				apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
				`CHK("moving", 1'b0, rd[TWS_HCF_BIT])
				wait_irq(2);
				repeat (22) @(posedge clk);
				apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
				`CHK("complete", 1'b1, rd[TWS_HCF_BIT])
				`CHK("data event", 1'b0, rd[TWS_ADDRESS_MATCH_FLAG_BIT])
				apb(1'b0, TWS_OFF_DATA, 32'h0);
				`CHK("rx byte", 32'h0000003c, rd)
			end
		join
		`CHK("addr ack", 1'b0, ack)
		`CHK("data ack", 1'b0, ack2)
		i_tws_bus_master_model.stop();
		// master reads two bytes, takes the first and refuses the second
		i_tws_bus_master_model.start();
		fork
			begin
				i_tws_bus_master_model.xbyte(8'h55, 1'b1, q, ack);
				i_tws_bus_master_model.xbyte(8'hff, 1'b0, q2, ack2);
				i_tws_bus_master_model.xbyte(8'hff, 1'b1, q3, ack3);
			end
			begin
				wait_irq(3);
				repeat (22) @(posedge clk);
				apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
				`CHK("dir read", 1'b1, rd[TWS_SRW_BIT])
				apb(1'b1, TWS_OFF_CTLSTS, 32'h00000010);
				apb(1'b1, TWS_OFF_DATA, 32'h000000a5);
				wait_irq(4);
				repeat (22) @(posedge clk);
				apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
				`CHK("ack seen", 1'b0, rd[TWS_RECEIVE_ACK_FLAG_BIT])
				apb(1'b1, TWS_OFF_DATA, 32'h0000005a);
			end
		join
		`CHK("read ack", 1'b0, ack)
		`CHK("tx byte", 8'ha5, q2)
		`CHK("tx byte 2", 8'h5a, q3)
		apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
		`CHK("nack seen", 1'b1, rd[TWS_RECEIVE_ACK_FLAG_BIT])
		`CHK("sda freed", 1'b0, s_sda_oe)
		i_tws_bus_master_model.stop();
		apb(1'b0, TWS_OFF_CTLSTS, 32'h0);
		`CHK("free again", 1'b0, rd[TWS_HBB_BIT])
		summarize();
	end
endmodule // tb_tws_slave

`default_nettype wire
